// file: rtl/mux_bus_consts.svh
// timing and field constants for the multiplexed bus master
// assumes a 40 MHz core clock driving all bus sequencing
`ifndef MUX_BUS_CONSTS_SVH
`define MUX_BUS_CONSTS_SVH
`define MB_CLK_PERIOD_NS   25
`define MB_T_HALF_NS       25
`define MB_T_HALF_CYC      ((`MB_T_HALF_NS + `MB_CLK_PERIOD_NS - 1) / `MB_CLK_PERIOD_NS)
`define MB_ADDR_CYC        2
`define MB_STROBE_CYC      4
`define MB_FETCH_CYC       (`MB_STROBE_CYC - `MB_T_HALF_CYC)
`define MB_HOLD_CYC        1
`define MB_LO_BYTE         7:0
`define MB_HI_BYTE         15:8
`endif

// file: rtl/mux_bus_master.sv
// processor side of the multiplexed address/data bus
// assumes one request at a time from core logic; i_start taken only when o_busy is low
//
// What this block does
// - address first, then read or write strobe
// - opcode fetch strobe shorter by t/2
// - space select high for io, low memory
// - memory cycles present full 16-bit address
// - io port address copied to both bytes
// - write data valid across whole strobe
// - high byte on own lines, low multiplexed
`timescale 1ns/1ps
`include "mux_bus_consts.svh"

module mux_bus_master (
    // clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    // core request
    input  wire logic                   i_start,
    input  wire mux_bus_pkg::cyc_kind_t i_kind,
    input  wire logic                   i_io_write,
    input  wire logic [15:0]            i_addr,
    input  wire logic [7:0]             i_wdata,
    output logic                        o_busy,
    output logic                        o_done,
    output logic [7:0]                  o_rdata,
    // bus pins
    output logic [7:0]                  o_addr_hi,
    output logic [7:0]                  o_ad_out,
    output logic                        o_ad_oe,
    input  wire logic [7:0]             i_ad_in,
    output logic                        o_addr_latch,
    output logic                        o_rd_n,
    output logic                        o_wr_n,
    output logic                        o_io_sel
);

    typedef struct packed {
        mux_bus_pkg::bus_state_t st;
        logic [2:0]              cnt;
        logic                    wr;
        logic                    busy;
        logic                    done;
        logic [7:0]              rdata;
        logic [7:0]              addr_hi;
        logic [7:0]              ad_out;
        logic [7:0]              wdata;
        logic                    ad_oe;
        logic                    ale;
        logic                    rd_n;
        logic                    wr_n;
        logic                    io_sel;
        logic [2:0]              strobe_len;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ad sync: three stages, value accepted once last two agree
    logic [7:0] ad_s1_q;
    logic [7:0] ad_s2_q;
    logic [7:0] ad_s3_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ad_s1_q <= 8'h00;
            ad_s2_q <= 8'h00;
            ad_s3_q <= 8'h00;
        end else begin
            ad_s1_q <= i_ad_in;
            ad_s2_q <= ad_s1_q;
            ad_s3_q <= ad_s2_q;
        end
    end

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            mux_bus_pkg::ST_IDLE: begin
                if (i_start) begin
                    s_d.st   = mux_bus_pkg::ST_ADDR;
                    s_d.busy = 1'b1;
                    s_d.cnt  = 3'(`MB_ADDR_CYC - 1);
                    s_d.ale  = 1'b1;
                    s_d.ad_oe = 1'b1;
                    s_d.wdata = i_wdata;
                    s_d.io_sel = (i_kind == mux_bus_pkg::CYC_IO);
                    if (i_kind == mux_bus_pkg::CYC_IO) begin
                        // port number duplicated onto both bytes
                        s_d.addr_hi = i_addr[`MB_LO_BYTE];
                        s_d.ad_out  = i_addr[`MB_LO_BYTE];
                        s_d.wr      = i_io_write;
                    end else begin
                        s_d.addr_hi = i_addr[`MB_HI_BYTE];
                        s_d.ad_out  = i_addr[`MB_LO_BYTE];
                        s_d.wr      = (i_kind == mux_bus_pkg::CYC_MEM_WR);
                    end
                    s_d.strobe_len = (i_kind == mux_bus_pkg::CYC_FETCH)
                                   ? 3'(`MB_FETCH_CYC) : 3'(`MB_STROBE_CYC);
                end
            end
            mux_bus_pkg::ST_ADDR: begin
                s_d.ale = 1'b0;
                if (s_q.cnt != 3'h0) begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end else begin
                    // strobe only after the address phase ends
                    s_d.st  = mux_bus_pkg::ST_STROBE;
                    s_d.cnt = s_q.strobe_len - 3'h1;
                    if (s_q.wr) begin
                        s_d.wr_n   = 1'b0;
                        s_d.ad_out = s_q.wdata;
                    end else begin
                        s_d.rd_n  = 1'b0;
                        s_d.ad_oe = 1'b0;
                    end
                end
            end
            mux_bus_pkg::ST_STROBE: begin
                if (s_q.cnt != 3'h0) begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end else begin
                    s_d.st   = mux_bus_pkg::ST_HOLD;
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1; // data kept driven through release
                end
            end
            mux_bus_pkg::ST_HOLD: begin
                // sync chain now holds strobe-time data; taken once last two stages agree
                if (!s_q.wr && (ad_s2_q == ad_s3_q)) begin
                    s_d.rdata = ad_s3_q;
                end
                s_d.st     = mux_bus_pkg::ST_IDLE;
                s_d.ad_oe  = 1'b0;
                s_d.busy   = 1'b0;
                s_d.done   = 1'b1;
                s_d.io_sel = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '{st: mux_bus_pkg::ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_busy       = s_q.busy;
    assign o_done       = s_q.done;
    assign o_rdata      = s_q.rdata;
    assign o_addr_hi    = s_q.addr_hi;
    assign o_ad_out     = s_q.ad_out;
    assign o_ad_oe      = s_q.ad_oe;
    assign o_addr_latch = s_q.ale;
    assign o_rd_n       = s_q.rd_n;
    assign o_wr_n       = s_q.wr_n;
    assign o_io_sel     = s_q.io_sel;

    // strobe falls exactly the address phase after the latch pulse
    property p_addr_before_strobe;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(o_addr_latch) |-> (o_rd_n && o_wr_n) [*2] ##1 (!o_rd_n || !o_wr_n);
    endproperty
    a_addr_before_strobe: assert property (p_addr_before_strobe)
        else $error("strobe not after address phase");

    // fetch strobe lasts three cycles, normal read four
    property p_fetch_short;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (s_q.st == mux_bus_pkg::ST_IDLE && i_start && i_kind == mux_bus_pkg::CYC_FETCH)
        |-> ##3 $fell(o_rd_n) ##3 $rose(o_rd_n);
    endproperty
    a_fetch_short: assert property (p_fetch_short)
        else $error("fetch strobe length wrong");

    property p_read_len;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (s_q.st == mux_bus_pkg::ST_IDLE && i_start && i_kind == mux_bus_pkg::CYC_MEM_RD)
        |-> ##3 $fell(o_rd_n) ##4 $rose(o_rd_n);
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read strobe length wrong");

    property p_space_sel;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (s_q.st == mux_bus_pkg::ST_IDLE && i_start)
        |=> o_io_sel == (($past(i_kind) == mux_bus_pkg::CYC_IO));
    endproperty
    a_space_sel: assert property (p_space_sel)
        else $error("space select mismatch");

    property p_io_dup;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_addr_latch && o_io_sel) |-> o_addr_hi == o_ad_out;
    endproperty
    a_io_dup: assert property (p_io_dup)
        else $error("io port not duplicated");

    property p_mem_addr;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (s_q.st == mux_bus_pkg::ST_IDLE && i_start && i_kind != mux_bus_pkg::CYC_IO)
        |=> {o_addr_hi, o_ad_out} == $past(i_addr);
    endproperty
    a_mem_addr: assert property (p_mem_addr)
        else $error("memory address not presented");

    property p_wdata_edges;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $fell(o_wr_n) |-> o_ad_oe ##1 ((o_ad_oe && $stable(o_ad_out)) throughout
            (!o_wr_n [*3] ##1 o_wr_n));
    endproperty
    a_wdata_edges: assert property (p_wdata_edges)
        else $error("write data not held across strobe");

    property p_hi_lines;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!o_rd_n || !o_wr_n) |-> $stable(o_addr_hi);
    endproperty
    a_hi_lines: assert property (p_hi_lines)
        else $error("high address moved in strobe");

endmodule

// file: rtl/mux_bus_pkg.sv
// types for the multiplexed bus master
// assumes the constants header is included by the design file
package mux_bus_pkg;
    typedef enum logic [1:0] {
        CYC_MEM_RD,
        CYC_FETCH,
        CYC_MEM_WR,
        CYC_IO
    } cyc_kind_t;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_STROBE,
        ST_HOLD
    } bus_state_t;
endpackage

// file: tb/bus_target.sv
// memory and io target model on the multiplexed bus
// assumes the address comes with the latch pulse and data with the strobes
`timescale 1ns/1ps
module bus_target (
    // bus side
    input  wire logic        i_core_clk,
    input  wire logic [7:0]  i_addr_hi,
    input  wire logic [7:0]  i_ad_out,
    input  wire logic        i_addr_latch,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_io_sel,
    output logic      [7:0]  o_ad_in,
    // observation
    output logic      [15:0] o_addr,
    output logic             o_io,
    output int               o_len,
    output int               o_bad,
    output int               o_clash,
    output logic             o_lin
);
    logic [7:0] mem [0:65535];
    logic [7:0] io  [0:255];
    logic [7:0] last = 8'h00;
    logic [7:0] wd;
    logic       was_wr = 1'b0;
    int         cnt = 0;
    logic [7:0] mem_cs_n;
    logic [7:0] io_cs_n;
    logic       low_gate_b;
    logic       high_gate;
    logic [1:0] lin_cs_n;
    initial o_bad = 0;
    initial o_clash = 0;
    // minimal system: A12, A13 as selects; A14, A15 ignored so mirrors appear
    assign lin_cs_n   = {o_addr[13], o_addr[12]};
    // io decoder gated by space select on its active-low enable
    assign low_gate_b = ~i_io_sel;
    assign high_gate  = 1'b1;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            // 1k devices: offset on A0-9, select from A10-15, memory space only
            mem_cs_n[k] = !(!i_io_sel && o_addr[15:13] == 3'h0
                            && o_addr[12:10] == 3'(k));
            io_cs_n[k]  = !(high_gate && !low_gate_b && o_addr[15:13] == 3'h0
                            && o_addr[12:10] == 3'(k));
        end
    end
    // released bus shows the inverse of the last value
    assign o_ad_in = !i_rd_n ? (i_io_sel ? io[o_addr[7:0]] : mem[o_addr]) : ~last;
    always @(posedge i_core_clk) begin
        if (i_addr_latch) begin
            o_addr <= {i_addr_hi, i_ad_out};
        end
        if (!i_rd_n || !i_wr_n) begin
            o_io <= i_io_sel;
            o_lin <= (lin_cs_n == 2'b00);
            // never two selects in one cycle
            if ($countones(~{mem_cs_n, io_cs_n}) > 1) o_clash <= o_clash + 1;
            cnt <= cnt + 1;
            was_wr <= !i_wr_n;
            if (!i_rd_n) last <= o_ad_in;
            if (!i_wr_n && cnt == 0) wd <= i_ad_out;
            if (!i_wr_n && cnt != 0 && i_ad_out !== wd) o_bad <= o_bad + 1;
        end else if (cnt != 0) begin
            o_len <= cnt;
            cnt <= 0;
            was_wr <= 1'b0;
            // write taken at the first clock edge after the strobe is released
            if (was_wr) begin
                if (i_ad_out !== wd) o_bad <= o_bad + 1;
                if (o_io) io[o_addr[7:0]] <= wd;
                else mem[o_addr] <= wd;
                last <= wd;
            end
        end
    end
endmodule

// file: tb/multiplexed_bus_chip_select_decode_tb_top.sv
// self-checking bench for the multiplexed bus master
// assumes the target model answers every strobe with no wait
`timescale 1ns/1ps
module multiplexed_bus_chip_select_decode_tb_top;
    logic                   i_core_clk = 1'b0;
    logic                   i_rst_n = 1'b0;
    logic                   i_start = 1'b0;
    mux_bus_pkg::cyc_kind_t i_kind = mux_bus_pkg::CYC_MEM_RD;
    logic                   i_io_write = 1'b0;
    logic [15:0]            i_addr = 16'h0000;
    logic [7:0]             i_wdata = 8'h00;
    logic [7:0]             o_rdata, o_addr_hi, o_ad_out, i_ad_in;
    logic                   o_busy, o_done, o_ad_oe, o_addr_latch, o_rd_n, o_wr_n, o_io_sel;
    logic [15:0]            t_addr;
    logic                   t_io;
    logic                   t_lin;
    int                     t_len, t_bad, t_clash;
    int                     compares = 0;
    int                     err_count = 0;
    int                     rm[int];
    int                     ri[int];
    logic [31:0]            seed = 32'h00016a7b;

    mux_bus_master dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_kind(i_kind), .i_io_write(i_io_write), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_addr_hi(o_addr_hi),
        .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe), .i_ad_in(i_ad_in),
        .o_addr_latch(o_addr_latch), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_io_sel(o_io_sel));
    bus_target tgt (.i_core_clk(i_core_clk), .i_addr_hi(o_addr_hi), .i_ad_out(o_ad_out),
        .i_addr_latch(o_addr_latch), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_io_sel(o_io_sel),
        .o_ad_in(i_ad_in), .o_addr(t_addr), .o_io(t_io), .o_len(t_len), .o_bad(t_bad),
        .o_clash(t_clash), .o_lin(t_lin));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic op(input mux_bus_pkg::cyc_kind_t k, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
        int  n;
        bit  io;
        n = 0;
        io = (k == mux_bus_pkg::CYC_IO);
        @(posedge i_core_clk);
        i_start <= 1'b1;
        i_kind <= k;
        i_io_write <= w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_start <= 1'b0;
        #1;
        chk("busy", 16'(o_busy), 16'h0001);
        while (o_done !== 1'b1 && n < 30) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk("done", 16'(o_done), 16'h0001);
        chk("idle", 16'(o_busy), 16'h0000);
        chk("clash", 16'(t_clash), 16'h0000);
        chk("addr", t_addr, io ? {a[7:0], a[7:0]} : a);
        chk("space", 16'(t_io), 16'(io));
        chk("strobe", 16'(t_len), (k == mux_bus_pkg::CYC_FETCH) ? 16'h0003 : 16'h0004);
        if (k == mux_bus_pkg::CYC_MEM_WR || (io && w)) begin
            if (io) ri[a[7:0]] = d;
            else rm[a] = d;
            chk("wdata", 16'(t_bad), 16'h0000);
        end else begin
            chk("rdata", 16'(o_rdata), 16'(io ? ri[a[7:0]] : rm[a]));
        end
    endtask

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    initial begin
        #(25 * 20000);
        err_count++;
        test_done();
    end
    initial begin
        logic [15:0] a;
        logic [7:0]  d;
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            // same low-A12/A13 device answers at each 16k mirror
            op(mux_bus_pkg::CYC_MEM_WR, 1'b0, {2'(m), 14'h0123}, 8'h5a);
            chk("mirror", 16'(t_lin), 16'h0001);
        end
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            a = seed[15:0];
            seed = lfsr(seed);
            d = seed[23:16];
            op(mux_bus_pkg::CYC_MEM_WR, 1'b0, a, d);
            op(mux_bus_pkg::CYC_MEM_RD, 1'b0, a, 8'h00);
            op(mux_bus_pkg::CYC_FETCH, 1'b0, a, 8'h00);
            op(mux_bus_pkg::CYC_IO, 1'b1, a, ~d);
            op(mux_bus_pkg::CYC_IO, 1'b0, a, 8'h00);
            op(mux_bus_pkg::CYC_MEM_RD, 1'b0, a, 8'h00);
        end
        test_done();
    end
endmodule
